// *** core/pmr_map.svh ***
// Purpose: offsets, field positions and reset values of the rail register slice
// Assumes: byte-wide registers behind an i2c target port
// Notes: definitions only
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH

// target address on the bus, value is arbitrary
`define PMR_DEV_ADDR 7'h2a

`define PMR_OFS_FORCE_SHUTDOWN 8'h91
`define PMR_OFS_RAIL1_SLEEP 8'h92
`define PMR_OFS_RAIL2_SLEEP 8'h93
`define PMR_OFS_RAIL3_VOLTAGE 8'h94

`define PMR_BIT_TRIGGER 0
`define PMR_BIT_SLEEP_ENABLE 0
`define PMR_BIT_DECAY 0
`define PMR_CODE_MSB 7
`define PMR_CODE_LSB 1

`define PMR_RST_FORCE_SHUTDOWN 8'h00
`define PMR_RST_RAIL_REG 8'h00
`define PMR_RST_UNMAPPED 8'h00
`define PMR_BITS_PER_BYTE 4'h8

`endif

// *** core/pmr_pkg.sv ***
// Purpose: types of the rail register slice
// Assumes: constants live in pmr_map.svh
// Notes: none
package pmr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } pmr_i2c_state_t;

    typedef logic [6:0] pmr_code_t;

endpackage

// *** core/pmr_sync.sv ***
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs idle high
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
module pmr_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] next_q;

    always_comb begin
        next_q = q;
        for (int i = 0; i < W; i++) begin
            if (ff2[i] == ff3[i]) begin
                next_q[i] = ff3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ff1 <= '1;
            ff2 <= '1;
            ff3 <= '1;
            q <= '1;
        end else begin
            ff1 <= d;
            ff2 <= ff1;
            ff3 <= ff2;
            q <= next_q;
        end
    end
endmodule

// *** core/pmr_regs.sv ***
// Purpose: shutdown trigger and rail voltage registers behind an i2c target port
// Assumes: scl/sda and sleep pins asynchronous; factory inputs static straps
// Notes: pointer auto-increments on every data byte except a write that sets the trigger
// Overview of operation
// - writing 1 to trigger bit starts emergency shutdown and resets all registers
// - trigger bit clears itself; software never writes it back to zero
// - write that sets the trigger is not acknowledged; host expects that
// - shutdown register resets to zero; bits 7:1 read zero, only bit 0 writable
// - rail1 sleep register bits 7:1 hold rail1 sleep voltage code
// - rail1 uses sleep code when enabled and its sleep pin is low
// - each rail's sleep pin choice is factory fixed, not software changeable
// - rail2 sleep register bits 7:1 hold rail2 sleep voltage code
// - rail2 uses sleep code when enabled and its sleep pin is low
// - rail3 register bits 7:1 hold rail3 normal voltage code
// - on lower rail3 code, bit 0 picks active slew or passive decay
`timescale 1ns/100ps
`include "pmr_map.svh"
module pmr_regs (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sleep_select_pin_a,
    input wire logic sleep_select_pin_b,
    input wire logic [7:0] factory_rail1_sleep_reset,
    input wire logic [7:0] factory_rail2_sleep_reset,
    input wire logic [7:0] factory_rail3_voltage_reset,
    input wire logic factory_rail1_pin_select,
    input wire logic factory_rail2_pin_select,
    input wire logic [6:0] rail1_normal_voltage_code,
    input wire logic [6:0] rail2_normal_voltage_code,
    output logic [6:0] rail1_voltage_code,
    output logic [6:0] rail2_voltage_code,
    output logic [6:0] rail3_voltage_code,
    output logic rail3_passive_decay_select,
    output logic rail3_active_slew_req,
    output logic rail3_passive_decay_req,
    output logic emergency_shutdown
);
    logic [3:0] pins_q;
    logic scl, sda, scl_d, sda_d, scl_rise, scl_fall, bus_start, bus_stop;

    pmr_pkg::pmr_i2c_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift, ptr, next_ptr, rd_byte;
    logic rw, next_rw, oe, next_oe, wr_en;

    logic loaded, next_loaded, trigger, next_trigger, next_slew_req, next_decay_req;
    logic rail1_pin_sel, next_rail1_pin_sel, rail2_pin_sel, next_rail2_pin_sel;
    logic [7:0] rail1_sleep_control, next_rail1_sleep_control, rail2_sleep_control, next_rail2_sleep_control;
    logic [7:0] rail3_voltage_control, next_rail3_voltage_control;
    pmr_pkg::pmr_code_t next_rail1_code, next_rail2_code, next_rail3_code;

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] r1,
                                            input logic [7:0] r2, input logic [7:0] r3);
        logic [7:0] v;
        v = `PMR_RST_UNMAPPED;
        if (a == `PMR_OFS_FORCE_SHUTDOWN) begin
            v = `PMR_RST_FORCE_SHUTDOWN;
        end else if (a == `PMR_OFS_RAIL1_SLEEP) begin
            v = r1;
        end else if (a == `PMR_OFS_RAIL2_SLEEP) begin
            v = r2;
        end else if (a == `PMR_OFS_RAIL3_VOLTAGE) begin
            v = r3;
        end
        return v;
    endfunction

    // sleep request of a rail: its factory-chosen pin is low
    function automatic logic pin_low(input logic sel, input logic pa, input logic pb);
        return sel ? !pb : !pa;
    endfunction

    pmr_sync #(.W(4)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d({sleep_select_pin_b, sleep_select_pin_a, sda_in, scl_in}),
        .q(pins_q)
    );

    assign scl = pins_q[0];
    assign sda = pins_q[1];
    assign scl_rise = scl && !scl_d;
    assign scl_fall = !scl && scl_d;
    assign bus_start = scl && scl_d && !sda && sda_d;
    assign bus_stop = scl && scl_d && sda && !sda_d;
    assign rd_byte = reg_read(ptr, rail1_sleep_control, rail2_sleep_control, rail3_voltage_control);
    assign sda_out = 1'b0;
    assign sda_oe = oe;
    assign emergency_shutdown = trigger;

    // i2c target sequencing
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_ptr = ptr;
        next_rw = rw;
        next_oe = oe;
        wr_en = 1'b0;
        if (trigger || !loaded) begin
            next_state = pmr_pkg::ST_IDLE;
            next_oe = 1'b0;
            next_ptr = 8'h00;
        end else if (bus_start) begin
            next_state = pmr_pkg::ST_ADDR;
            next_cnt = 4'h0;
            next_oe = 1'b0;
        end else if (bus_stop) begin
            next_state = pmr_pkg::ST_IDLE;
            next_oe = 1'b0;
        end else if (scl_rise) begin
            unique case (state)
                pmr_pkg::ST_ADDR, pmr_pkg::ST_PTR, pmr_pkg::ST_WDATA: begin
                    next_shift = {shift[6:0], sda};
                    next_cnt = cnt + 4'h1;
                end
                pmr_pkg::ST_RACK: begin
                    if (sda) begin
                        next_state = pmr_pkg::ST_IDLE;
                    end
                end
                pmr_pkg::ST_IDLE, pmr_pkg::ST_ADDR_ACK, pmr_pkg::ST_WACK, pmr_pkg::ST_RDATA: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state)
                pmr_pkg::ST_ADDR: begin
                    if (cnt == `PMR_BITS_PER_BYTE) begin
                        if (shift[7:1] == `PMR_DEV_ADDR) begin
                            next_rw = shift[0];
                            next_oe = 1'b1;
                            next_state = pmr_pkg::ST_ADDR_ACK;
                        end else begin
                            next_state = pmr_pkg::ST_IDLE;
                        end
                    end
                end
                pmr_pkg::ST_PTR: begin
                    if (cnt == `PMR_BITS_PER_BYTE) begin
                        next_ptr = shift;
                        next_oe = 1'b1;
                        next_state = pmr_pkg::ST_WACK;
                    end
                end
                pmr_pkg::ST_WDATA: begin
                    if (cnt == `PMR_BITS_PER_BYTE) begin
                        wr_en = 1'b1;
                        if (ptr == `PMR_OFS_FORCE_SHUTDOWN && shift[`PMR_BIT_TRIGGER]) begin
                            next_state = pmr_pkg::ST_IDLE;
                        end else begin
                            next_oe = 1'b1;
                            next_ptr = ptr + 8'h01;
                            next_state = pmr_pkg::ST_WACK;
                        end
                    end
                end
                pmr_pkg::ST_ADDR_ACK, pmr_pkg::ST_RACK: begin
                    next_cnt = 4'h1;
                    if (state == pmr_pkg::ST_RACK || rw) begin
                        next_shift = rd_byte;
                        next_oe = !rd_byte[7];
                        next_ptr = ptr + 8'h01;
                        next_state = pmr_pkg::ST_RDATA;
                    end else begin
                        next_cnt = 4'h0;
                        next_oe = 1'b0;
                        next_state = pmr_pkg::ST_PTR;
                    end
                end
                pmr_pkg::ST_WACK: begin
                    next_cnt = 4'h0;
                    next_oe = 1'b0;
                    next_state = pmr_pkg::ST_WDATA;
                end
                pmr_pkg::ST_RDATA: begin
                    if (cnt == `PMR_BITS_PER_BYTE) begin
                        next_oe = 1'b0;
                        next_state = pmr_pkg::ST_RACK;
                    end else begin
                        next_shift = {shift[6:0], 1'b0};
                        next_oe = !shift[6];
                        next_cnt = cnt + 4'h1;
                    end
                end
                pmr_pkg::ST_IDLE: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= pmr_pkg::ST_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            oe <= 1'b0;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            ptr <= next_ptr;
            rw <= next_rw;
            oe <= next_oe;
        end
    end

    // register bank and rail outputs
    always_comb begin
        next_loaded = 1'b1;
        next_trigger = 1'b0;
        next_rail1_sleep_control = rail1_sleep_control;
        next_rail2_sleep_control = rail2_sleep_control;
        next_rail3_voltage_control = rail3_voltage_control;
        next_rail1_pin_sel = rail1_pin_sel;
        next_rail2_pin_sel = rail2_pin_sel;
        if (trigger) begin
            next_loaded = 1'b0;
            next_rail1_sleep_control = `PMR_RST_RAIL_REG;
            next_rail2_sleep_control = `PMR_RST_RAIL_REG;
            next_rail3_voltage_control = `PMR_RST_RAIL_REG;
        end else if (!loaded) begin
            next_rail1_sleep_control = factory_rail1_sleep_reset;
            next_rail2_sleep_control = factory_rail2_sleep_reset;
            next_rail3_voltage_control = factory_rail3_voltage_reset;
            next_rail1_pin_sel = factory_rail1_pin_select;
            next_rail2_pin_sel = factory_rail2_pin_select;
        end else if (wr_en) begin
            if (ptr == `PMR_OFS_FORCE_SHUTDOWN) begin
                next_trigger = shift[`PMR_BIT_TRIGGER];
            end else if (ptr == `PMR_OFS_RAIL1_SLEEP) begin
                next_rail1_sleep_control = shift;
            end else if (ptr == `PMR_OFS_RAIL2_SLEEP) begin
                next_rail2_sleep_control = shift;
            end else if (ptr == `PMR_OFS_RAIL3_VOLTAGE) begin
                next_rail3_voltage_control = shift;
            end
        end
        next_rail1_code = rail1_normal_voltage_code;
        if (rail1_sleep_control[`PMR_BIT_SLEEP_ENABLE] && pin_low(rail1_pin_sel, pins_q[2], pins_q[3])) begin
            next_rail1_code = rail1_sleep_control[`PMR_CODE_MSB:`PMR_CODE_LSB];
        end
        next_rail2_code = rail2_normal_voltage_code;
        if (rail2_sleep_control[`PMR_BIT_SLEEP_ENABLE] && pin_low(rail2_pin_sel, pins_q[2], pins_q[3])) begin
            next_rail2_code = rail2_sleep_control[`PMR_CODE_MSB:`PMR_CODE_LSB];
        end
        next_rail3_code = rail3_voltage_control[`PMR_CODE_MSB:`PMR_CODE_LSB];
        next_slew_req = 1'b0;
        next_decay_req = 1'b0;
        if (loaded && next_rail3_code < rail3_voltage_code) begin
            next_slew_req = !rail3_voltage_control[`PMR_BIT_DECAY];
            next_decay_req = rail3_voltage_control[`PMR_BIT_DECAY];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            loaded <= 1'b0;
            trigger <= 1'b0;
            rail1_sleep_control <= `PMR_RST_RAIL_REG;
            rail2_sleep_control <= `PMR_RST_RAIL_REG;
            rail3_voltage_control <= `PMR_RST_RAIL_REG;
            rail1_pin_sel <= 1'b0;
            rail2_pin_sel <= 1'b0;
            rail1_voltage_code <= 7'h00;
            rail2_voltage_code <= 7'h00;
            rail3_voltage_code <= 7'h00;
            rail3_passive_decay_select <= 1'b0;
            rail3_active_slew_req <= 1'b0;
            rail3_passive_decay_req <= 1'b0;
        end else begin
            loaded <= next_loaded;
            trigger <= next_trigger;
            rail1_sleep_control <= next_rail1_sleep_control;
            rail2_sleep_control <= next_rail2_sleep_control;
            rail3_voltage_control <= next_rail3_voltage_control;
            rail1_pin_sel <= next_rail1_pin_sel;
            rail2_pin_sel <= next_rail2_pin_sel;
            rail1_voltage_code <= next_rail1_code;
            rail2_voltage_code <= next_rail2_code;
            rail3_voltage_code <= next_rail3_code;
            rail3_passive_decay_select <= rail3_voltage_control[`PMR_BIT_DECAY];
            rail3_active_slew_req <= next_slew_req;
            rail3_passive_decay_req <= next_decay_req;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    shutdown_reload_a: assert property (trigger |=> !loaded ##1 loaded && state == pmr_pkg::ST_IDLE)
        else $error("shutdown did not reload the registers");
    trigger_clear_a: assert property (trigger |=> !trigger [*2])
        else $error("shutdown trigger did not clear itself");
    trigger_nack_a: assert property (wr_en && ptr == `PMR_OFS_FORCE_SHUTDOWN && shift[0] |=> !sda_oe [*3])
        else $error("trigger write was acknowledged");
    reserved_zero_a: assert property (scl_fall && loaded && !trigger && ptr == `PMR_OFS_FORCE_SHUTDOWN
                                      && (state == pmr_pkg::ST_RACK || state == pmr_pkg::ST_ADDR_ACK && rw)
                                      |=> shift == 8'h00 && sda_oe)
        else $error("shutdown register read not zero");
    rail1_select_a: assert property (loaded && !rail1_sleep_control[0] ##1 loaded
                                     |-> rail1_voltage_code == $past(rail1_normal_voltage_code))
        else $error("rail1 left normal code while disabled");
    rail1_sleep_a: assert property (rail1_sleep_control[0] && pin_low(rail1_pin_sel, pins_q[2], pins_q[3])
                                    |=> rail1_voltage_code == $past(rail1_sleep_control[7:1]))
        else $error("rail1 sleep code not applied");
    pin_fixed_a: assert property (loaded && !trigger |=> $stable(rail1_pin_sel) && $stable(rail2_pin_sel))
        else $error("sleep pin assignment changed");
    rail2_select_a: assert property (rail2_sleep_control[0] && pin_low(rail2_pin_sel, pins_q[2], pins_q[3])
                                     |=> rail2_voltage_code == $past(rail2_sleep_control[7:1]))
        else $error("rail2 sleep code not applied");
    rail3_code_a: assert property (loaded && $stable(rail3_voltage_control) [*2]
                                   |-> rail3_voltage_code == rail3_voltage_control[7:1])
        else $error("rail3 code not following register");
    rail3_decay_a: assert property (loaded && rail3_voltage_control[7:1] < rail3_voltage_code
                                    |=> rail3_passive_decay_req == $past(rail3_voltage_control[0])
                                        && rail3_active_slew_req != rail3_passive_decay_req)
        else $error("rail3 down transition mode wrong");
    factory_load_a: assert property (!loaded && !trigger
                                     |=> rail1_sleep_control == $past(factory_rail1_sleep_reset)
                                     && rail3_voltage_control == $past(factory_rail3_voltage_reset))
        else $error("factory reset values not loaded");

    shutdown_c: cover property (trigger);
    read_byte_c: cover property (state == pmr_pkg::ST_RACK);
    rail1_sleep_c: cover property (rail1_sleep_control[0] && pin_low(rail1_pin_sel, pins_q[2], pins_q[3]));
    rail3_decay_c: cover property (rail3_passive_decay_req);
endmodule

// *** verification/pmr_i2c_host.sv ***
// Purpose: i2c host model facing the register slice
// Assumes: open-drain bus with pull-ups, wire levels resolved by the bench
// Notes: scl stays high ten system clocks and low twelve in each data bit
`timescale 1ns/100ps
module pmr_i2c_host (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask

    task automatic start_cond();
        sda_pull = 1'b0;
        wait_clk(10);
        scl = 1'b1;
        wait_clk(10);
        sda_pull = 1'b1;
        wait_clk(10);
        scl = 1'b0;
        wait_clk(2);
    endtask

    task automatic stop_cond();
        sda_pull = 1'b1;
        wait_clk(10);
        scl = 1'b1;
        wait_clk(10);
        sda_pull = 1'b0;
        wait_clk(10);
    endtask

    // sda sampled late in the high phase, changed only while scl is low
    task automatic bit_xfer(input logic b, output logic s);
        sda_pull = !b;
        wait_clk(10);
        scl = 1'b1;
        wait_clk(10);
        s = sda_line;
        scl = 1'b0;
        wait_clk(2);
    endtask

    // missing ack is reported back, never treated as a bus fault
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
        bit_xfer(1'b1, s);
        ack = !s;
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        bit_xfer(last, s);
    endtask
endmodule

// *** verification/pmr_regs_tb.sv ***
// Purpose: self-checking bench of the rail register slice
// Assumes: straps fixed for the run, rail1 on pin a, rail2 on pin b
// Notes: inputs change 10 ns after the rising edge
`timescale 1ns/100ps
`include "pmr_map.svh"
module pmr_regs_tb;
    localparam logic [7:0] fac1 = 8'h5c;
    localparam logic [7:0] fac2 = 8'h3b;
    localparam logic [7:0] fac3 = 8'ha8;
    logic clk_sys, rstn, scl, sda_pull, sda_line, sda_out, sda_oe;
    logic sleep_select_pin_a, sleep_select_pin_b;
    logic [6:0] n1, n2, rail1_voltage_code, rail2_voltage_code, rail3_voltage_code;
    logic rail3_passive_decay_select, rail3_active_slew_req, rail3_passive_decay_req, emergency_shutdown;
    int fail_count, checks_done, slew_cnt, decay_cnt, emergency_shutdown_trigger_cnt;

    assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

    pmr_i2c_host u_pmr_i2c_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

    pmr_regs u_pmr_regs (
        .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .sleep_select_pin_a(sleep_select_pin_a), .sleep_select_pin_b(sleep_select_pin_b),
        .factory_rail1_sleep_reset(fac1), .factory_rail2_sleep_reset(fac2), .factory_rail3_voltage_reset(fac3),
        .factory_rail1_pin_select(1'b0), .factory_rail2_pin_select(1'b1),
        .rail1_normal_voltage_code(n1), .rail2_normal_voltage_code(n2),
        .rail1_voltage_code(rail1_voltage_code), .rail2_voltage_code(rail2_voltage_code),
        .rail3_voltage_code(rail3_voltage_code), .rail3_passive_decay_select(rail3_passive_decay_select),
        .rail3_active_slew_req(rail3_active_slew_req), .rail3_passive_decay_req(rail3_passive_decay_req),
        .emergency_shutdown(emergency_shutdown)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // pulse counters for the one-cycle outputs
    always @(posedge clk_sys) begin
        if (rail3_active_slew_req === 1'b1) slew_cnt++;
        if (rail3_passive_decay_req === 1'b1) decay_cnt++;
        if (emergency_shutdown === 1'b1) emergency_shutdown_trigger_cnt++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask

    task automatic clear_counts();
        slew_cnt = 0;
        decay_cnt = 0;
        emergency_shutdown_trigger_cnt = 0;
    endtask

    task automatic wr_regs(input logic [7:0] ptr, input logic [7:0] q[$], output logic last_ack);
        logic a;
        u_pmr_i2c_host.start_cond();
        u_pmr_i2c_host.wr_byte({`PMR_DEV_ADDR, 1'b0}, a);
        check({7'h00, a}, 8'h01);
        u_pmr_i2c_host.wr_byte(ptr, a);
        check({7'h00, a}, 8'h01);
        foreach (q[i]) u_pmr_i2c_host.wr_byte(q[i], last_ack);
        u_pmr_i2c_host.stop_cond();
    endtask

    // pointer set, repeated start, burst read, each byte compared
    task automatic rd_check(input logic [7:0] ptr, input logic [7:0] exp[$]);
        logic a;
        logic [7:0] d;
        u_pmr_i2c_host.start_cond();
        u_pmr_i2c_host.wr_byte({`PMR_DEV_ADDR, 1'b0}, a);
        u_pmr_i2c_host.wr_byte(ptr, a);
        u_pmr_i2c_host.start_cond();
        u_pmr_i2c_host.wr_byte({`PMR_DEV_ADDR, 1'b1}, a);
        foreach (exp[i]) begin
            u_pmr_i2c_host.rd_byte(i == exp.size() - 1, d);
            check(d, exp[i]);
        end
        u_pmr_i2c_host.stop_cond();
    endtask

    task automatic test_reset();
        rd_check(`PMR_OFS_FORCE_SHUTDOWN, {8'h00, fac1, fac2, fac3});
        check({1'b0, rail3_voltage_code}, {1'b0, fac3[7:1]});
        check({7'h00, rail3_passive_decay_select}, {7'h00, fac3[0]});
    endtask

    // zero to the trigger, rail writes, unmapped byte at the end
    task automatic test_rw();
        logic a;
        clear_counts();
        wr_regs(`PMR_OFS_FORCE_SHUTDOWN, {8'hfe, 8'h8b, 8'h57, 8'h64, 8'hff}, a);
        check({7'h00, a}, 8'h01);
        check(emergency_shutdown_trigger_cnt[7:0], 8'h00);
        check(slew_cnt[7:0], 8'h01);
        check(decay_cnt[7:0], 8'h00);
        rd_check(`PMR_OFS_FORCE_SHUTDOWN, {8'h00, 8'h8b, 8'h57, 8'h64, 8'h00});
    endtask

    task automatic test_rail3();
        logic a;
        logic [7:0] val [4] = '{8'h65, 8'h21, 8'h7e, 8'h10};
        logic [7:0] exp_slew [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
        logic [7:0] exp_decay [4] = '{8'h00, 8'h01, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) begin
            clear_counts();
            wr_regs(`PMR_OFS_RAIL3_VOLTAGE, {val[i]}, a);
            check(slew_cnt[7:0], exp_slew[i]);
            check(decay_cnt[7:0], exp_decay[i]);
            check({1'b0, rail3_voltage_code}, {1'b0, val[i][7:1]});
            check({7'h00, rail3_passive_decay_select}, {7'h00, val[i][0]});
        end
    endtask

    task automatic test_sleep();
        logic a;
        logic [6:0] e1, e2;
        for (int en = 1; en >= 0; en--) begin
            wr_regs(`PMR_OFS_RAIL1_SLEEP, {8'h8a | en[7:0], 8'h56 | en[7:0]}, a);
            n1 = 7'h11 + en[6:0];
            n2 = 7'h22 + en[6:0];
            for (int p = 0; p < 4; p++) begin
                sleep_select_pin_a = p[1];
                sleep_select_pin_b = p[0];
                tick(10);
                e1 = (en == 1 && !p[1]) ? 7'h45 : n1;
                e2 = (en == 1 && !p[0]) ? 7'h2b : n2;
                check({1'b0, rail1_voltage_code}, {1'b0, e1});
                check({1'b0, rail2_voltage_code}, {1'b0, e2});
            end
        end
    endtask

    // trigger value sent to a foreign address first: refused, no shutdown
    task automatic test_shutdown();
        logic a;
        clear_counts();
        u_pmr_i2c_host.start_cond();
        u_pmr_i2c_host.wr_byte({`PMR_DEV_ADDR ^ 7'h01, 1'b0}, a);
        check({7'h00, a}, 8'h00);
        u_pmr_i2c_host.wr_byte(`PMR_OFS_FORCE_SHUTDOWN, a);
        u_pmr_i2c_host.wr_byte(8'h01, a);
        u_pmr_i2c_host.stop_cond();
        check(emergency_shutdown_trigger_cnt[7:0], 8'h00);
        wr_regs(`PMR_OFS_FORCE_SHUTDOWN, {8'h01}, a);
        check({7'h00, a}, 8'h00);
        check(emergency_shutdown_trigger_cnt[7:0], 8'h01);
        rd_check(`PMR_OFS_FORCE_SHUTDOWN, {8'h00, fac1, fac2, fac3});
    endtask

    initial begin
        #(40000 * 100);
        fail_count++;
        report_and_stop();
    end

    initial begin
        fail_count = 0;
        checks_done = 0;
        clear_counts();
        rstn = 1'b0;
        sleep_select_pin_a = 1'b1;
        sleep_select_pin_b = 1'b1;
        n1 = 7'h11;
        n2 = 7'h22;
        tick(12);
        rstn = 1'b1;
        tick(10);
        test_reset();
        test_rw();
        test_rail3();
        test_sleep();
        test_shutdown();
        report_and_stop();
    end
endmodule
